/* File: core/pcd_pkg.sv */
package pcd_pkg;

  // Register word indices; the byte address is four times the index
  localparam logic [15:0] PCD_IDX_LOCK     = 16'h00a3;
  localparam logic [15:0] PCD_IDX_CLKSEL   = 16'h2867;
  localparam logic [15:0] PCD_IDX_PLLMODE  = 16'h2868;
  localparam logic [15:0] PCD_IDX_ANSTAT   = 16'h286b;
  localparam logic [15:0] PCD_IDX_IRQSTAT  = 16'h2870;
  localparam logic [15:0] PCD_IDX_IRQMASK  = 16'h2871;
  localparam int          PCD_ADDR_LSB     = 2;
  localparam int          PCD_ADDR_W       = 18;

  // Reset values and the fixed analog status field
  localparam logic [7:0]  PCD_CLKSEL_RST   = 8'h00;
  localparam logic [7:0]  PCD_PLLMODE_RST  = 8'h00;
  localparam logic [2:0]  PCD_ANSTAT_FIXED = 3'h5;
  localparam logic [2:0]  PCD_IRQ_RST      = 3'h0;

  // Clock select fields
  localparam int PCD_PLL_EN_BIT     = 7;
  localparam int PCD_BG_EN_BIT      = 6;
  localparam int PCD_ADC_MUL_LSB    = 4;
  localparam int PCD_MET_MUL_LSB    = 2;
  localparam int PCD_CPU_MUL_LSB    = 0;
  // PLL mode fields
  localparam int PCD_QUAD_BIT       = 7;
  localparam int PCD_DOUBLE_BIT     = 6;
  localparam int PCD_MAINS_BIT      = 5;
  // Analog status fields
  localparam int PCD_OSC_FAIL_BIT   = 7;
  localparam int PCD_CMPB_BIT       = 5;
  localparam int PCD_FIXED_LSB      = 2;
  // Interrupt bits
  localparam int PCD_IRQ_LOCK       = 0;
  localparam int PCD_IRQ_OSC        = 1;
  localparam int PCD_IRQ_CMPB       = 2;
  localparam int PCD_IRQ_N          = 3;

  // Multiplier codes
  localparam logic [1:0] PCD_MUL_X1 = 2'h0;
  localparam logic [1:0] PCD_MUL_X2 = 2'h1;
  localparam logic [1:0] PCD_MUL_X4 = 2'h2;
  localparam logic [1:0] PCD_MUL_X8 = 2'h3;

  // Base rates in Hz; processor base 819.2 kHz times 8 is the 6.5 MHz setting
  localparam int PCD_ADC_BASE_HZ = 204800;
  localparam int PCD_MET_BASE_HZ = 819200;
  localparam int PCD_CPU_BASE_HZ = 819200;

  localparam logic [1:0] PCD_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] PCD_HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic       pllPowerEnable;
    logic       bandgapPowerEnable;
    logic [1:0] samplingClockMultiplier;
    logic [1:0] meteringClockMultiplier;
    logic [1:0] processorClockMultiplier;
  } pcd_clksel_t;

  typedef struct packed {
    logic       processorClockQuadruple;
    logic       processorClockDouble;
    logic       mainsFrequencySelect;
    logic [4:0] reserved;
  } pcd_pllmode_t;

  // Analog-side controls driven out of the block
  typedef struct packed {
    logic        pllPowerEnable;
    logic        bandgapPowerEnable;
    logic        mainsFrequencySelect;
    logic [3:0]  samplingClockRatio;
    logic [3:0]  meteringClockRatio;
    logic [5:0]  processorClockRatio;
  } pcd_ctrl_t;

endpackage : pcd_pkg

/* File: core/pcd_sync.sv */
module pcd_sync
  import pcd_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  // Stage one feeds stage two only; a change counts once two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
      syncOut  <= 1'b0;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      if (stage2_r == stage3_r) begin
        syncOut <= stage3_r;
      end
    end
  end

endmodule : pcd_sync

/* File: core/pcd_clock_control.sv */
// Implementation choice: the AHB-Lite interface to the registers.
module pcd_clock_control
  import pcd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        pllLockIn,
  input  wire logic        oscFailIn,
  input  wire logic        comparatorBIn,
  output pcd_ctrl_t        ctrlOut,
  output logic             irqOut
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic pllLocked;
  logic oscFailed;
  logic cmpB;

  pcd_sync uLockSync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (pllLockIn),
    .syncOut (pllLocked)
  );

  pcd_sync uOscSync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (oscFailIn),
    .syncOut (oscFailed)
  );

  pcd_sync uCmpSync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (comparatorBIn),
    .syncOut (cmpB)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture

  logic                  wrPend_r;
  logic                  rdPend_r;
  logic [PCD_ADDR_W-1:0] addr_r;
  logic                  wordAccess;
  logic                  addrPhase;

  // Sub-word and burst transfers are not decoded; software uses whole single words
  assign wordAccess = (hsize == PCD_HSIZE_WORD);
  assign addrPhase  = hsel && hready && (htrans == PCD_HTRANS_NONSEQ) && wordAccess;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_r <= 1'b0;
    end else begin
      wrPend_r <= addrPhase && hwrite;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdPend_r <= 1'b0;
    end else begin
      rdPend_r <= addrPhase && !hwrite;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= '0;
    end else begin
      if (addrPhase) begin
        addr_r <= haddr[PCD_ADDR_W+PCD_ADDR_LSB-1:PCD_ADDR_LSB];
      end
    end
  end

  // One wait state on reads so hrdata comes from flops when sampled; always OKAY
  assign hreadyout = !rdPend_r;
  assign hresp     = 1'b0;

  function automatic logic hitIdx(input logic [PCD_ADDR_W-1:0] a, input logic [15:0] idx);
    hitIdx = (a == {{(PCD_ADDR_W-16){1'b0}}, idx});
  endfunction : hitIdx

  logic selClk;
  logic selMode;
  logic selStat;
  logic selMask;
  logic selLock;
  logic selAn;

  assign selClk  = hitIdx(addr_r, PCD_IDX_CLKSEL);
  assign selMode = hitIdx(addr_r, PCD_IDX_PLLMODE);
  assign selStat = hitIdx(addr_r, PCD_IDX_IRQSTAT);
  assign selMask = hitIdx(addr_r, PCD_IDX_IRQMASK);
  assign selLock = hitIdx(addr_r, PCD_IDX_LOCK);
  assign selAn   = hitIdx(addr_r, PCD_IDX_ANSTAT);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  pcd_clksel_t  clkSel_r;
  pcd_pllmode_t pllMode_r;

  // Only these two and the interrupt status and mask take writes; lock and analog status have no storage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clkSel_r <= pcd_clksel_t'(PCD_CLKSEL_RST);
    end else if (wrPend_r && selClk) begin
      clkSel_r <= pcd_clksel_t'(hwdata[7:0]);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pllMode_r <= pcd_pllmode_t'(PCD_PLLMODE_RST);
    end else if (wrPend_r && selMode) begin
      pllMode_r <= pcd_pllmode_t'(hwdata[7:0]); // Reserved bits stored as written
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock ratio decode

  function automatic logic [3:0] mulRatio(input logic [1:0] code);
    case (code)
      PCD_MUL_X1: mulRatio = 4'h1;
      PCD_MUL_X2: mulRatio = 4'h2;
      PCD_MUL_X4: mulRatio = 4'h4;
      default:    mulRatio = 4'h8;
    endcase
  endfunction : mulRatio

  logic [3:0] cpuBase;
  logic [5:0] cpuRatio;
  logic       cpuAtTop;

  assign cpuBase  = mulRatio(clkSel_r.processorClockMultiplier);
  assign cpuAtTop = (clkSel_r.processorClockMultiplier == PCD_MUL_X8);

  always_comb begin
    cpuRatio = {2'h0, cpuBase};
    if (cpuAtTop && pllMode_r.processorClockDouble) begin
      cpuRatio = 6'h10;
      if (pllMode_r.processorClockQuadruple) begin
        cpuRatio = 6'h20;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog-side control outputs

  // Ratios are multiples of each base rate; one flop per field keeps outputs glitch free
  logic       pllEn_r;
  logic       bgEn_r;
  logic       mains_r;
  logic [3:0] adcRatio_r;
  logic [3:0] metRatio_r;
  logic [5:0] cpuRatio_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pllEn_r <= 1'b0;
    end else begin
      pllEn_r <= clkSel_r.pllPowerEnable;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bgEn_r <= 1'b0;
    end else begin
      bgEn_r <= clkSel_r.bandgapPowerEnable;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mains_r <= 1'b0;
    end else begin
      mains_r <= pllMode_r.mainsFrequencySelect;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adcRatio_r <= '0;
    end else begin
      adcRatio_r <= mulRatio(clkSel_r.samplingClockMultiplier);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      metRatio_r <= '0;
    end else begin
      metRatio_r <= mulRatio(clkSel_r.meteringClockMultiplier);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpuRatio_r <= '0;
    end else begin
      cpuRatio_r <= cpuRatio;
    end
  end

  always_comb begin
    ctrlOut.pllPowerEnable       = pllEn_r;
    ctrlOut.bandgapPowerEnable   = bgEn_r;
    ctrlOut.mainsFrequencySelect = mains_r;
    ctrlOut.samplingClockRatio   = adcRatio_r;
    ctrlOut.meteringClockRatio   = metRatio_r;
    ctrlOut.processorClockRatio  = cpuRatio_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: lock gained, oscillator failover, comparator B change

  logic [PCD_IRQ_N-1:0] irqStat_r;
  logic [PCD_IRQ_N-1:0] irqMask_r;
  logic [PCD_IRQ_N-1:0] evPrev_r;
  logic [PCD_IRQ_N-1:0] evNow;
  logic [PCD_IRQ_N-1:0] evHit;
  logic [PCD_IRQ_N-1:0] clrBits;

  assign evNow   = {cmpB, oscFailed, pllLocked};
  assign clrBits = (wrPend_r && selStat) ? hwdata[PCD_IRQ_N-1:0] : '0;

  genvar g;
  generate
    for (g = 0; g < PCD_IRQ_N; g++) begin : gEvt
      if (g == PCD_IRQ_CMPB) begin : gAny
        assign evHit[g] = evNow[g] ^ evPrev_r[g];
      end else begin : gRise
        assign evHit[g] = evNow[g] & ~evPrev_r[g];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      evPrev_r <= '0;
    end else begin
      evPrev_r <= evNow;
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_r <= PCD_IRQ_RST;
    end else begin
      irqStat_r <= (irqStat_r & ~clrBits) | evHit;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqMask_r <= PCD_IRQ_RST;
    end else if (wrPend_r && selMask) begin
      irqMask_r <= hwdata[PCD_IRQ_N-1:0];
    end
  end

  assign irqOut = |(irqStat_r & irqMask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] lockWord;
  logic [7:0] anWord;
  logic [7:0] rdByte;

  always_comb begin
    lockWord                   = 8'h00;
    lockWord[0]                = pllLocked;
    anWord                     = 8'h00;
    anWord[PCD_OSC_FAIL_BIT]   = oscFailed;
    anWord[PCD_CMPB_BIT]       = cmpB;
    anWord[PCD_FIXED_LSB +: 3] = PCD_ANSTAT_FIXED;
  end

  always_comb begin
    rdByte = 8'h00;
    if (selLock) begin
      rdByte = lockWord;
    end else if (selAn) begin
      rdByte = anWord;
    end else if (selClk) begin
      rdByte = clkSel_r;
    end else if (selMode) begin
      rdByte = pllMode_r;
    end else if (selStat) begin
      rdByte = {5'h00, irqStat_r};
    end else if (selMask) begin
      rdByte = {5'h00, irqMask_r};
    end
  end

  // Loaded in the read wait cycle; stands until the next read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rdPend_r) begin
      hrdata <= {24'h00_0000, rdByte};
    end
  end

endmodule : pcd_clock_control

/* File: verification/pcd_clock_control_assertions.sv */
module pcd_clock_control_assertions
  import pcd_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire pcd_ctrl_t   ctrlOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  logic wrClk_r;
  logic wrMode_r;
  logic rdLock_r;
  logic rdAn_r;
  assign take = hsel && hready && htrans == PCD_HTRANS_NONSEQ;
  // Flags mark the data phase of clock select and PLL mode writes and of lock and analog status reads
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrClk_r  <= 1'b0;
      wrMode_r <= 1'b0;
      rdLock_r <= 1'b0;
      rdAn_r   <= 1'b0;
    end else begin
      wrClk_r  <= take && hwrite && haddr == 32'h0000_a19c;
      wrMode_r <= take && hwrite && haddr == 32'h0000_a1a0;
      rdLock_r <= take && !hwrite && haddr == 32'h0000_028c;
      rdAn_r   <= take && !hwrite && haddr == 32'h0000_a1ac;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_pll_power: assert property (
    wrClk_r |-> ##2 ctrlOut.pllPowerEnable == $past(hwdata[7], 2)) else $error("pll enable");
  a_bandgap_power: assert property (
    wrClk_r |-> ##2 ctrlOut.bandgapPowerEnable == $past(hwdata[6], 2)) else $error("bg enable");
  a_adc_ratio: assert property (
    wrClk_r |-> ##2 ctrlOut.samplingClockRatio == 4'h1 << $past(hwdata[5:4], 2))
    else $error("adc ratio");
  a_met_ratio: assert property (
    wrClk_r |-> ##2 ctrlOut.meteringClockRatio == 4'h1 << $past(hwdata[3:2], 2))
    else $error("met ratio");
  a_cpu_ratio: assert property (
    wrClk_r && hwdata[1:0] != 2'h3 |-> ##2
    ctrlOut.processorClockRatio == 6'h01 << $past(hwdata[1:0], 2)) else $error("cpu ratio");
  a_cpu_onehot: assert property (
    $past(reset_n) && $past(reset_n, 2) |-> $onehot(ctrlOut.processorClockRatio))
    else $error("cpu ratio not power of two");
  a_mains_select: assert property (
    wrMode_r |-> ##2 ctrlOut.mainsFrequencySelect == $past(hwdata[5], 2)) else $error("mains");
  a_lock_upper: assert property (
    rdLock_r |=> hrdata[31:1] == 31'h0) else $error("lock upper bits");
  a_anstat_fixed: assert property (
    rdAn_r |=> hrdata[4:2] == PCD_ANSTAT_FIXED && hrdata[31:8] == 24'h0) else $error("fixed");
endmodule : pcd_clock_control_assertions

bind pcd_clock_control pcd_clock_control_assertions chk (.clk(clk), .reset_n(reset_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .ctrlOut(ctrlOut));

/* File: verification/test_pcd_clock_control.sv */
module test_pcd_clock_control;
  timeunit 1ns;
  timeprecision 1ps;
  import pcd_pkg::*;
  logic        clk, reset_n, hsel, hwrite, hreadyout, hresp, irqOut, chk;
  logic        pllLockIn, oscFailIn, comparatorBIn;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  c, m, e;
  logic [15:0] q;
  logic [15:0] expQ[$];
  pcd_ctrl_t   ctrlOut;
  int          mismatches, compares, cycles, seed;

  pcd_clock_control uut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pllLockIn(pllLockIn),
    .oscFailIn(oscFailIn), .comparatorBIn(comparatorBIn), .ctrlOut(ctrlOut), .irqOut(irqOut));
  ////////////////////////////////////////
  task automatic final_report;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic cmpOut(input string n, input logic [7:0] ex, input logic [7:0] s);
    compares++;
    if (s !== ex) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, ex, s);
    end
  endtask : cmpOut

  task automatic cmpReg(input logic [7:0] mk, input logic [7:0] ex);
    compares++;
    if ({hrdata[31:8], hrdata[7:0] & mk} !== {24'h0, ex}) begin
      mismatches++;
      $display("unexpected hrdata expected %h seen %h", ex, hrdata);
    end
  endtask : cmpReg

  // Single transfer; hreadyout is the bus ready
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= PCD_HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {14'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    chk    <= !w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    chk    <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [15:0] idx, input logic [7:0] mk, input logic [7:0] ex);
    expQ.push_back({mk, ex});
    xfer(1'b0, idx, 8'h00);
  endtask : rd
  ////////////////////////////////////////
  // Read data is taken at the edge that ends the data phase
  always @(posedge clk) begin
    if (chk && hreadyout === 1'b1) begin
      q = expQ.pop_front();
      cmpReg(q[15:8], q[7:0]);
      cmpOut("hresp", 8'h00, 8'(hresp));
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {reset_n, hsel, hwrite, chk, pllLockIn, oscFailIn, comparatorBIn} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = PCD_HSIZE_WORD;
    seed = 32'h419f;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(PCD_IDX_CLKSEL, 8'hff, PCD_CLKSEL_RST);
    rd(PCD_IDX_PLLMODE, 8'hff, PCD_PLLMODE_RST);
    for (int i = 0; i < 16; i++) begin
      c = 8'($random(seed));
      m = 8'($random(seed));
      c[5:4] = 2'(i % 3); // Code 11 unspecified
      c[3:2] = 2'((i + 1) % 3);
      c[1:0] = 2'(i);
      c[6] = c[6] | c[7];
      m[7:6] = 2'(i >> 2);
      m[4:0] = 5'h00;
      xfer(1'b1, PCD_IDX_CLKSEL, c & 8'h7f); // Bandgap before PLL
      xfer(1'b1, PCD_IDX_CLKSEL, c);
      xfer(1'b1, PCD_IDX_PLLMODE, m);
      rd(PCD_IDX_CLKSEL, 8'hff, c);
      rd(PCD_IDX_PLLMODE, 8'hff, m);
      @(negedge clk);
      e = (c[1:0] == 2'h3 && m[6]) ? (m[7] ? 8'h20 : 8'h10) : 8'h01 << c[1:0];
      cmpOut("pll", 8'(c[7]), 8'(ctrlOut.pllPowerEnable));
      cmpOut("bg", 8'(c[6]), 8'(ctrlOut.bandgapPowerEnable));
      cmpOut("mains", 8'(m[5]), 8'(ctrlOut.mainsFrequencySelect));
      cmpOut("adc", 8'h01 << c[5:4], 8'(ctrlOut.samplingClockRatio));
      cmpOut("met", 8'h01 << c[3:2], 8'(ctrlOut.meteringClockRatio));
      cmpOut("cpu", e, 8'(ctrlOut.processorClockRatio));
    end
    @(posedge clk);
    {pllLockIn, oscFailIn, comparatorBIn} <= 3'h7;
    repeat (8) @(posedge clk);
    xfer(1'b1, PCD_IDX_LOCK, 8'hfe);
    xfer(1'b1, PCD_IDX_ANSTAT, 8'h00);
    rd(PCD_IDX_LOCK, 8'hff, 8'h01);
    rd(PCD_IDX_ANSTAT, 8'hbc, 8'hb4);
    rd(PCD_IDX_IRQSTAT, 8'h07, 8'h07);
    @(negedge clk);
    cmpOut("irq masked", 8'h00, 8'(irqOut));
    xfer(1'b1, PCD_IDX_IRQMASK, 8'h04);
    @(negedge clk);
    cmpOut("irq", 8'h01, 8'(irqOut));
    xfer(1'b1, PCD_IDX_IRQSTAT, 8'h04);
    @(negedge clk);
    cmpOut("irq cleared", 8'h00, 8'(irqOut));
    rd(PCD_IDX_IRQSTAT, 8'h07, 8'h03);
    @(posedge clk);
    {pllLockIn, oscFailIn, comparatorBIn} <= 3'h0;
    repeat (8) @(posedge clk);
    rd(PCD_IDX_LOCK, 8'hff, 8'h00);
    rd(PCD_IDX_ANSTAT, 8'hbc, 8'h14);
    cmpOut("irq again", 8'h01, 8'(irqOut));
    xfer(1'b1, 16'h2869, 8'hff);
    rd(16'h2869, 8'hff, 8'h00);
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule : test_pcd_clock_control
